// ===== common/ramp_defines.vh
// Constants for the LED breathing ramp update block.
`ifndef RAMP_DEFINES_VH
`define RAMP_DEFINES_VH

// ****************************************************************
// Register byte offsets on the Avalon-MM slave
// ****************************************************************
`define OFS_LAMP_CONFIG   5'h00
`define OFS_RAMP_STATUS   5'h04
`define OFS_STEP_SIZES    5'h0C
`define OFS_INTERVALS     5'h10
`define OFS_TURN_ON_SKEW  5'h14

// ****************************************************************
// Field positions in lamp_config_reg
// ****************************************************************
`define CFG_RUN_BIT       0
`define CFG_EVEN_BIT      1
`define CFG_UPD_BIT       2
`define CFG_SYNC_BIT      3
`define CFG_TIMEBASE_BIT  4
`define CFG_RES_LSB       5

// ****************************************************************
// Field positions in the ramp status register
// ****************************************************************
`define STS_FALLING_BIT   8
`define STS_ON_BIT        9
`define STS_SEG_LSB       10

// ****************************************************************
// Resolution codes, clip limits and reset values
// ****************************************************************
`define RES_8BIT          2'h0
`define RES_7BIT          2'h1
`define RES_6BIT          2'h2
`define MAX_8BIT          8'hFF
`define MAX_7BIT          8'h7F
`define MAX_6BIT          8'h3F
`define RST_WORD          32'h0000_0000
`define RST_SKEW          8'h00
`define RST_DUTY          8'h00

`endif

// ===== logic/hold_reg.v
// Register with a software holding copy and an active copy.
`timescale 1ns/1ps

module hold_reg #(
   parameter        WIDTH     = 32,
   parameter [31:0] RST_VALUE = 32'h0000_0000
) (
   input  wire             ref_clk,
   input  wire             rst,
   input  wire             load,
   input  wire [WIDTH-1:0] load_data,
   input  wire             apply,
   output reg  [WIDTH-1:0] hold_q,
   output reg  [WIDTH-1:0] active_q
);

   // ****************************************************************
   // Holding copy
   // ****************************************************************

   // Software may write at any time; the value waits here unseen.
   always @(posedge ref_clk) begin
      if (rst) begin
         hold_q <= RST_VALUE[WIDTH-1:0];
      end else if (load) begin
         hold_q <= load_data;
      end
   end

   // ****************************************************************
   // Active copy
   // ****************************************************************

   // The active copy only moves at a period end with update enabled.
   // A write landing on the same edge as the apply is still held and
   // moves over at the next apply.
   always @(posedge ref_clk) begin
      if (rst) begin
         active_q <= RST_VALUE[WIDTH-1:0];
      end else if (apply) begin
         active_q <= hold_q; // [RULE6]
      end
   end

endmodule

// ===== logic/led_breathing_ramp_update.v
// Ramp update logic of a breathing LED PWM unit, with Avalon-MM registers.
//
// Notes on behaviour
// (RULE1) Period end adjusts duty by indexed step field.
// (RULE2) Eight 4-bit interval fields, one per segment.
// (RULE3) Interval N waits N plus one periods.
// (RULE4) Symmetric index is duty bits 7:5.
// (RULE5) Asymmetric index: falling flag, duty bits 7:6.
// (RULE6) Writes held, applied at period end if enabled.
// (RULE7) Reads return active copy, not held value.
// (RULE8) Delay turn-on after enable, resume, sync.
// (RULE9) Delay counts selected timebase; zero adds none.
// (RULE10) Software gives each output a distinct delay.
// (RULE11) Step N is N+1; low bits dropped by resolution.
// (RULE12) Add rising, subtract falling, clip to range.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "ramp_defines.vh"

module led_breathing_ramp_update #(
   parameter DUTY_W  = 8,
   parameter SKEW_W  = 8,
   parameter FIELD_W = 4
) (
   input  wire              ref_clk,
   input  wire              rst,
   input  wire [4:0]        avs_address,
   input  wire              avs_read,
   input  wire              avs_write,
   input  wire [31:0]       avs_writedata,
   input  wire [3:0]        avs_byteenable,
   output reg  [31:0]       avs_readdata,
   output reg               avs_waitrequest,
   input  wire              pwm_period_end,
   input  wire              slow_tick,
   input  wire              resume_pulse,
   output reg  [DUTY_W-1:0] duty_q,
   output reg               ramp_falling_q,
   output reg               led_on_q
);

   // ****************************************************************
   // Turn-on state machine codes
   // ****************************************************************
   localparam [2:0] ST_IDLE = 3'b001; // Output held off.
   localparam [2:0] ST_WAIT = 3'b010; // Counting the turn-on skew.
   localparam [2:0] ST_ON   = 3'b100; // Output running.

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg              run_en_q;        // Ramp and output enable.
   reg              run_en_prev_q;   // Last enable, for edge detect.
   reg              even_ramp_q;     // even_ramp_select: symmetric index.
   reg              upd_en_q;        // Enable update of active copies from holding copies.
   reg              timebase_q;      // timebase_select: 1 uses slow_tick.
   reg  [1:0]       res_q;           // Duty resolution code.
   reg              sync_evt_q;      // One-cycle pulse from a sync write.
   reg  [SKEW_W-1:0] skew_q;         // Turn-on skew count.
   reg  [FIELD_W-1:0] wait_cnt_q;    // Periods seen since last update.
   reg  [2:0]       state_q;         // Turn-on state.
   reg  [SKEW_W-1:0] delay_cnt_q;    // Remaining skew counts.
   reg  [31:0]      rd_mux;          // Read data selected by address.
   wire [31:0]      step_hold;       // Pending step sizes.
   wire [31:0]      step_act;        // Active step sizes.
   wire [31:0]      intv_hold;       // Pending intervals.
   wire [31:0]      intv_act;        // Active intervals.
   wire             wr_go;           // Write commits on this edge.
   wire             apply;           // Holding copies move over.
   wire [2:0]       seg_idx;         // Current segment index.
   wire [FIELD_W-1:0] step_field;    // Step field for this segment.
   wire [FIELD_W-1:0] intv_field;    // Interval field for this segment.
   wire [DUTY_W-1:0] step_amt;       // Resolved step amount.
   wire [DUTY_W-1:0] duty_max;       // Clip ceiling for resolution.
   wire [DUTY_W:0]  duty_sum;        // Rising sum with carry.
   wire             ramp_go;         // Ramp may move this period.
   wire             start_evt;       // Any turn-on trigger.
   wire             tick;            // One count of the skew timebase.

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Picks the 4-bit field of a word that a segment index names.
   function [3:0] pick_field;
      input [31:0] word;
      input [2:0]  idx;
      begin
         pick_field = word[{idx, 2'b00} +: 4]; // [RULE1] [RULE2]
      end
   endfunction

   // Merges write data into an old word under the byte enables.
   function [31:0] merge_bytes;
      input [31:0] old;
      input [31:0] wdata;
      input [3:0]  be;
      integer      i;
      begin
         merge_bytes = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge_bytes[i*8 +: 8] = wdata[i*8 +: 8];
            end
         end
      end
   endfunction

   // Turns a step field into a duty change. The field means N plus
   // one, and coarser resolutions drop the low bits so the ramp keeps
   // the same shape over a smaller range.
   function [7:0] step_amount;
      input [3:0] field;
      input [1:0] res;
      begin
         case (res)
            `RES_8BIT: step_amount = {4'h0, field} + 8'h01;        // [RULE11]
            `RES_7BIT: step_amount = {5'h00, field[3:1]} + 8'h01;  // [RULE11]
            default:   step_amount = {6'h00, field[3:2]} + 8'h01;  // [RULE11]
         endcase
      end
   endfunction

   // Highest duty value allowed at a resolution.
   function [7:0] res_limit;
      input [1:0] res;
      begin
         case (res)
            `RES_8BIT: res_limit = `MAX_8BIT;
            `RES_7BIT: res_limit = `MAX_7BIT;
            default:   res_limit = `MAX_6BIT;
         endcase
      end
   endfunction

   // ****************************************************************
   // Bus handshake
   // ****************************************************************

   // A request is seen with waitrequest high, answered one cycle later
   // with waitrequest low, and committed at the edge that samples it
   // low. Waitrequest rises again at once, so every access costs two
   // edges and never more.
   always @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= `RST_WORD;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : `RST_WORD;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   assign wr_go = avs_write && !avs_waitrequest;
   assign apply = pwm_period_end && upd_en_q; // [RULE6]

   // ****************************************************************
   // Read decode
   // ****************************************************************

   // Ramp registers read back their active copy, so software sees
   // what the hardware uses. Unmapped offsets read as zero.
   always @* begin
      rd_mux = `RST_WORD;
      if (avs_address == `OFS_LAMP_CONFIG) begin
         rd_mux[`CFG_RUN_BIT]      = run_en_q;
         rd_mux[`CFG_EVEN_BIT]     = even_ramp_q;
         rd_mux[`CFG_UPD_BIT]      = upd_en_q;
         rd_mux[`CFG_TIMEBASE_BIT] = timebase_q;
         rd_mux[`CFG_RES_LSB +: 2] = res_q;
      end else if (avs_address == `OFS_RAMP_STATUS) begin
         rd_mux[DUTY_W-1:0]        = duty_q;
         rd_mux[`STS_FALLING_BIT]  = ramp_falling_q;
         rd_mux[`STS_ON_BIT]       = led_on_q;
         rd_mux[`STS_SEG_LSB +: 3] = seg_idx;
      end else if (avs_address == `OFS_STEP_SIZES) begin
         rd_mux = step_act;   // [RULE7]
      end else if (avs_address == `OFS_INTERVALS) begin
         rd_mux = intv_act;   // [RULE7]
      end else if (avs_address == `OFS_TURN_ON_SKEW) begin
         rd_mux[SKEW_W-1:0] = skew_q;
      end
   end

   // ****************************************************************
   // Configuration and skew registers
   // ****************************************************************

   // The sync bit is a command, not a state: writing one raises a
   // single-cycle event and the bit reads back as zero.
   always @(posedge ref_clk) begin
      if (rst) begin
         run_en_q    <= 1'b0;
         even_ramp_q <= 1'b0;
         upd_en_q    <= 1'b0;
         timebase_q  <= 1'b0;
         res_q       <= `RES_8BIT;
         sync_evt_q  <= 1'b0;
         skew_q      <= `RST_SKEW;
      end else begin
         sync_evt_q <= 1'b0;
         if (wr_go && avs_address == `OFS_LAMP_CONFIG && avs_byteenable[0]) begin
            run_en_q    <= avs_writedata[`CFG_RUN_BIT];
            even_ramp_q <= avs_writedata[`CFG_EVEN_BIT];
            upd_en_q    <= avs_writedata[`CFG_UPD_BIT];
            timebase_q  <= avs_writedata[`CFG_TIMEBASE_BIT];
            res_q       <= avs_writedata[`CFG_RES_LSB +: 2];
            sync_evt_q  <= avs_writedata[`CFG_SYNC_BIT];
         end
         if (wr_go && avs_address == `OFS_TURN_ON_SKEW && avs_byteenable[0]) begin
            skew_q <= avs_writedata[SKEW_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Step and interval registers with holding copies
   // ****************************************************************

   hold_reg #(
      .WIDTH     (32),
      .RST_VALUE (`RST_WORD)
   ) step_regs (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (wr_go && avs_address == `OFS_STEP_SIZES),
      .load_data (merge_bytes(step_hold, avs_writedata, avs_byteenable)),
      .apply     (apply),
      .hold_q    (step_hold),
      .active_q  (step_act)
   );

   hold_reg #(
      .WIDTH     (32),
      .RST_VALUE (`RST_WORD)
   ) intv_regs (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (wr_go && avs_address == `OFS_INTERVALS),
      .load_data (merge_bytes(intv_hold, avs_writedata, avs_byteenable)),
      .apply     (apply),
      .hold_q    (intv_hold),
      .active_q  (intv_act)
   );

   // ****************************************************************
   // Segment selection
   // ****************************************************************

   // Symmetric ramps share one profile up and down; asymmetric ramps
   // give the falling half its own four segments.
   assign seg_idx = even_ramp_q ? duty_q[7:5]                    // [RULE4]
                                : {ramp_falling_q, duty_q[7:6]}; // [RULE5]

   assign step_field = pick_field(step_act, seg_idx); // [RULE1]
   assign intv_field = pick_field(intv_act, seg_idx); // [RULE2]
   assign step_amt   = step_amount(step_field, res_q);
   assign duty_max   = res_limit(res_q);
   assign duty_sum   = {1'b0, duty_q} + {1'b0, step_amt};
   assign ramp_go    = pwm_period_end && run_en_q && (state_q == ST_ON);

   // ****************************************************************
   // Duty ramp
   // ****************************************************************

   // Counts period ends in the current segment and moves the duty once
   // the count reaches the interval field, so field N spans N plus one
   // periods. The counter restarts after each move, which means a new
   // segment's interval takes effect at once, counted from the move into it.
   always @(posedge ref_clk) begin
      if (rst) begin
         duty_q         <= `RST_DUTY;
         ramp_falling_q <= 1'b0;
         wait_cnt_q     <= {FIELD_W{1'b0}};
      end else if (!run_en_q) begin
         duty_q         <= `RST_DUTY;
         ramp_falling_q <= 1'b0;
         wait_cnt_q     <= {FIELD_W{1'b0}};
      end else if (ramp_go) begin
         if (wait_cnt_q >= intv_field) begin // [RULE3]
            wait_cnt_q <= {FIELD_W{1'b0}};
            if (!ramp_falling_q) begin
               // Rising: clip at the ceiling and turn round there.
               if (duty_sum >= {1'b0, duty_max}) begin // [RULE12]
                  duty_q         <= duty_max;
                  ramp_falling_q <= 1'b1;
               end else begin
                  duty_q <= duty_sum[DUTY_W-1:0]; // [RULE1] [RULE12]
               end
            end else begin
               // Falling: clip at zero and turn round there.
               if (duty_q <= step_amt) begin // [RULE12]
                  duty_q         <= `RST_DUTY;
                  ramp_falling_q <= 1'b0;
               end else begin
                  duty_q <= duty_q - step_amt; // [RULE1] [RULE12]
               end
            end
         end else begin
            wait_cnt_q <= wait_cnt_q + {{(FIELD_W-1){1'b0}}, 1'b1}; // [RULE3]
         end
      end
   end

   // ****************************************************************
   // Turn-on skew
   // ****************************************************************

   // Skew counts either every clock or slow timebase ticks only.
   assign tick = timebase_q ? slow_tick : 1'b1; // [RULE9]

   // Enable rising, a resume from sleep or a sync command restart the
   // delay. The output stays off while counting so that several LEDs
   // given distinct skews switch on at distinct moments, spreading
   // the inrush current.
   assign start_evt = run_en_q && ((!run_en_prev_q) || resume_pulse || sync_evt_q); // [RULE8]

   // Turn-on state machine; disable always wins and drops the output.
   always @(posedge ref_clk) begin
      if (rst) begin
         state_q       <= ST_IDLE;
         delay_cnt_q   <= {SKEW_W{1'b0}};
         led_on_q      <= 1'b0;
         run_en_prev_q <= 1'b0;
      end else begin
         run_en_prev_q <= run_en_q;
         if (!run_en_q) begin
            state_q  <= ST_IDLE;
            led_on_q <= 1'b0;
         end else if (start_evt) begin
            delay_cnt_q <= skew_q;
            if (skew_q == {SKEW_W{1'b0}}) begin // [RULE9]
               state_q  <= ST_ON;
               led_on_q <= 1'b1;
            end else begin
               state_q  <= ST_WAIT; // [RULE8]
               led_on_q <= 1'b0;
            end
         end else begin
            case (state_q)
               ST_WAIT: begin
                  if (tick) begin
                     if (delay_cnt_q == {{(SKEW_W-1){1'b0}}, 1'b1}) begin // [RULE8]
                        state_q  <= ST_ON;
                        led_on_q <= 1'b1;
                     end else begin
                        delay_cnt_q <= delay_cnt_q - {{(SKEW_W-1){1'b0}}, 1'b1};
                     end
                  end
               end
               ST_ON: begin
                  led_on_q <= 1'b1;
               end
               default: begin
                  state_q  <= ST_IDLE;
                  led_on_q <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

// ===== dv/led_breathing_ramp_update_chk.sv
// Concurrent checks on the ports of the LED breathing ramp update block.
`timescale 1ns/1ps
module led_breathing_ramp_update_chk #(
   parameter DUTY_W = 8
) (
   input wire              ref_clk,
   input wire              rst,
   input wire [4:0]        avs_address,
   input wire              avs_read,
   input wire              avs_write,
   input wire [31:0]       avs_readdata,
   input wire              avs_waitrequest,
   input wire              pwm_period_end,
   input wire [DUTY_W-1:0] duty_q,
   input wire              ramp_falling_q,
   input wire              led_on_q
);
   // *****
   // Bus and ramp properties
   // *****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Requests are answered after one cycle.
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("late answer");
   AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("long answer");
   AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address == 5'h1C |=> avs_readdata == 32'h0000_0000)
      else $error("unmapped data");
   // A drop to zero is the run-off case or the falling clip at zero.
   AST_DUTY_AT_PE: assert property ($changed(duty_q) && duty_q != 0 |-> $past(pwm_period_end) && $past(led_on_q))
      else $error("stray duty change");
   AST_RISE_STEP: assert property ($changed(duty_q) && duty_q != 0 && !$past(ramp_falling_q)
      |-> duty_q > $past(duty_q) && duty_q - $past(duty_q) <= 8'd16)
      else $error("rise step");
   AST_FALL_STEP: assert property ($changed(duty_q) && duty_q != 0 && $past(ramp_falling_q)
      |-> duty_q < $past(duty_q) && $past(duty_q) - duty_q <= 8'd16)
      else $error("fall step");
   AST_FALL_AT_MAX: assert property ($rose(ramp_falling_q) |-> duty_q == 8'hFF || duty_q == 8'h7F || duty_q == 8'h3F)
      else $error("early turn");
   AST_RESET_VALS: assert property ($fell(rst) |-> duty_q == 8'h00 && !led_on_q && !ramp_falling_q && avs_waitrequest)
      else $error("reset values");
   C_FALL: cover property ($rose(ramp_falling_q));
   C_ON: cover property ($rose(led_on_q));
   C_WR: cover property (avs_write && !avs_waitrequest);
endmodule
bind led_breathing_ramp_update led_breathing_ramp_update_chk #(.DUTY_W(DUTY_W)) chk (
   .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_period_end(pwm_period_end),
   .duty_q(duty_q), .ramp_falling_q(ramp_falling_q), .led_on_q(led_on_q));

// ===== dv/led_pwm_model.sv
// Model of the PWM counter and LED pin on the far side of the ramp block.
`timescale 1ns/1ps
module led_pwm_model #(
   parameter PERIOD = 12,
   parameter TICK   = 5
) (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       pe_en,
   input  wire [7:0] duty_q,
   input  wire       led_on_q,
   output reg        pwm_period_end,
   output reg        slow_tick,
   output wire       led_pin
);
   reg [7:0] pwm_q;  // Position inside the PWM period.
   reg [3:0] tick_q; // Divider for the slow timebase.
   // LED lights while running and below the duty.
   assign led_pin = led_on_q && (pwm_q < duty_q);
   // Counters run freely, even while the bench idles.
   always @(posedge ref_clk) begin
      if (rst) begin
         pwm_q <= 8'h00;
         tick_q <= 4'h0;
         pwm_period_end <= 1'b0;
         slow_tick <= 1'b0;
      end else begin
         pwm_q <= (pwm_q == PERIOD - 1) ? 8'h00 : pwm_q + 8'h01;
         tick_q <= (tick_q == TICK - 1) ? 4'h0 : tick_q + 4'h1;
         pwm_period_end <= pe_en && (pwm_q == PERIOD - 1);
         slow_tick <= (tick_q == TICK - 1);
      end
   end
endmodule

// ===== dv/led_breathing_ramp_update_test.sv
// Self-checking testbench for the LED breathing ramp update block.
`timescale 1ns/1ps
`include "ramp_defines.vh"
module led_breathing_ramp_update_test;
   reg         ref_clk, rst, avs_read, avs_write, resume_pulse, pe_en;
   reg  [4:0]  avs_address;
   reg  [31:0] avs_writedata, rdata;
   reg  [3:0]  avs_byteenable;
   wire [31:0] avs_readdata;
   wire [7:0]  duty_q;
   wire        avs_waitrequest, pwm_period_end, slow_tick, ramp_falling_q, led_on_q, led_pin;
   integer     err_count, n_tests, n, t;
   reg  [7:0]  m_duty;             // Expected duty cycle.
   reg         m_fall;             // Expected ramp direction.
   reg  [3:0]  m_cnt;              // Expected period count since last update.
   reg  [31:0] m_steps, m_ivs, m_cfg;
   led_breathing_ramp_update dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_period_end(pwm_period_end),
      .slow_tick(slow_tick), .resume_pulse(resume_pulse), .duty_q(duty_q), .ramp_falling_q(ramp_falling_q),
      .led_on_q(led_on_q));
   led_pwm_model far (.ref_clk(ref_clk), .rst(rst), .pe_en(pe_en), .duty_q(duty_q), .led_on_q(led_on_q),
      .pwm_period_end(pwm_period_end), .slow_tick(slow_tick), .led_pin(led_pin));
   // *****
   // Shared tasks
   // *****
   task test_done;
      begin
         $display("checks %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task check(input [31:0] exp, input [31:0] got, input [8*10:1] what);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // A spent wait bound fails the run.
   task give_up;
      begin
         check(1, 0, "timeout");
         test_done;
      end
   endtask
   // Request stands until waitrequest is seen low.
   task bus(input wr, input [4:0] a, input [31:0] d);
      integer i;
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= !wr;
         avs_write <= wr;
         i = 0;
         do begin @(posedge ref_clk); i = i + 1; end while (avs_waitrequest !== 1'b0 && i < 50);
         if (i >= 50) give_up;
         rdata = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task do_reset;
      begin
         rst <= 1'b1;
         pe_en <= 1'b0;
         repeat (2) @(posedge ref_clk);
         rst <= 1'b0;
         @(posedge ref_clk);
         m_duty = 0; m_fall = 0; m_cnt = 0;
      end
   endtask
   // Waits for a period end.
   task wait_pe;
      integer i;
      begin
         i = 0;
         do begin @(posedge ref_clk); i = i + 1; end while (pwm_period_end !== 1'b1 && i < 100);
         if (i >= 100) give_up;
      end
   endtask
   // Cycles and slow ticks until turn-on.
   task wait_on;
      begin
         n = 0; t = 0;
         do begin @(posedge ref_clk); n = n + 1; t = t + slow_tick; end while (led_on_q !== 1'b1 && n < 300);
         if (n >= 300) give_up;
      end
   endtask
   // Expected duty at one period end.
   task model_step;
      reg [2:0] idx;
      reg [8:0] st, mx;
      begin
         idx = m_cfg[1] ? m_duty[7:5] : {m_fall, m_duty[7:6]};
         if (m_cnt < m_ivs[idx*4 +: 4]) m_cnt = m_cnt + 1;
         else begin
            m_cnt = 0;
            st = m_steps[idx*4 +: 4];
            st = (m_cfg[6:5] == 0) ? st + 1 : (m_cfg[6:5] == 1) ? st / 2 + 1 : st / 4 + 1;
            mx = (m_cfg[6:5] == 0) ? 255 : (m_cfg[6:5] == 1) ? 127 : 63;
            if (!m_fall && m_duty + st >= mx) begin m_duty = mx; m_fall = 1; end
            else if (!m_fall) m_duty = m_duty + st;
            else if (m_duty <= st) begin m_duty = 0; m_fall = 0; end
            else m_duty = m_duty - st;
         end
      end
   endtask
   // *****
   // Scenarios
   // *****
   task t_regs;
      begin
         bus(0, `OFS_STEP_SIZES, 0); check(0, rdata, "steps rst");
         bus(0, `OFS_INTERVALS, 0); check(0, rdata, "ivs rst");
         bus(0, `OFS_TURN_ON_SKEW, 0); check(0, rdata, "skew rst");
         bus(1, 5'h1C, 32'hFFFF_FFFF); bus(0, 5'h1C, 0); check(0, rdata, "unmapped");
         bus(1, `OFS_TURN_ON_SKEW, 32'h0000_00A5); bus(0, `OFS_TURN_ON_SKEW, 0); check(32'hA5, rdata, "skew");
      end
   endtask
   // Held writes apply only at a period end with update on.
   task t_hold;
      begin
         bus(1, `OFS_INTERVALS, 32'hF000_000F); pe_en <= 1'b1; wait_pe;
         bus(0, `OFS_INTERVALS, 0); check(0, rdata, "held");
         bus(1, `OFS_LAMP_CONFIG, 32'h0000_0004); wait_pe;
         bus(0, `OFS_INTERVALS, 0); check(32'hF000_000F, rdata, "applied");
         bus(1, `OFS_LAMP_CONFIG, 0); bus(1, `OFS_INTERVALS, 0); wait_pe;
         bus(0, `OFS_INTERVALS, 0); check(32'hF000_000F, rdata, "frozen");
         pe_en <= 1'b0;
      end
   endtask
   // Turn-on delay in slow ticks; resume and sync restart it.
   task t_delay;
      begin
         do_reset;
         bus(1, `OFS_TURN_ON_SKEW, 3); bus(1, `OFS_LAMP_CONFIG, 32'h0000_0011); wait_on;
         check(1, t >= 2 && t <= 4, "ticks en");
         resume_pulse <= 1'b1; @(posedge ref_clk); resume_pulse <= 1'b0; repeat (2) @(posedge ref_clk);
         check(0, led_on_q, "resume off"); wait_on; check(1, t >= 2 && t <= 4, "ticks res");
         bus(1, `OFS_LAMP_CONFIG, 32'h0000_0019); @(posedge ref_clk);
         check(0, led_on_q, "sync off"); wait_on; check(1, t >= 2 && t <= 4, "ticks syn");
         bus(1, `OFS_TURN_ON_SKEW, 0); bus(1, `OFS_LAMP_CONFIG, 0); bus(1, `OFS_LAMP_CONFIG, 1); wait_on;
         check(1, n, "zero skew");
      end
   endtask
   task t_ramp(input [31:0] cfg, input [31:0] steps, input [31:0] ivs, input integer np);
      integer k;
      begin
         do_reset; m_cfg = cfg; m_steps = steps; m_ivs = ivs;
         bus(1, `OFS_LAMP_CONFIG, 32'h0000_0004); bus(1, `OFS_STEP_SIZES, steps); bus(1, `OFS_INTERVALS, ivs);
         pe_en <= 1'b1; wait_pe; pe_en <= 1'b0;
         bus(0, `OFS_STEP_SIZES, 0); check(steps, rdata, "steps");
         bus(1, `OFS_LAMP_CONFIG, cfg); wait_on; pe_en <= 1'b1;
         for (k = 0; k < np; k = k + 1) begin
            wait_pe; @(posedge ref_clk); model_step;
            check(m_duty, duty_q, "duty");
            check(m_fall, ramp_falling_q, "falling");
         end
         pe_en <= 1'b0;
      end
   endtask
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      rst = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0; avs_byteenable = 4'hF;
      resume_pulse = 0; pe_en = 0; err_count = 0; n_tests = 0;
      do_reset;
      t_regs;
      t_hold;
      t_delay;
      t_ramp(32'h0000_0007, 32'h0000_0052, 32'h0000_0001, 30);
      t_ramp(32'h0000_0027, 32'h0000_000B, 32'h0000_0000, 12);
      t_ramp(32'h0000_0045, 32'h0006_000F, 32'h0000_0000, 22);
      test_done;
   end
endmodule
